// ---- eswc_defs.svh ----
// register offsets, field positions, masks and reset values of the statistics window bank
`ifndef ESWC_DEFS_SVH
`define ESWC_DEFS_SVH

// register offsets on the user-side register port
`define ESWC_OFF_GEOMETRY 8'h00
`define ESWC_OFF_START 8'h04
`define ESWC_OFF_BLACK 8'h08
`define ESWC_OFF_SUBSAMPLE 8'h0C
`define ESWC_OFF_BASE 8'h10
`define ESWC_OFF_OUT_CFG 8'h14
`define ESWC_OFF_LINE 8'h18
`define ESWC_OFF_FIR1 8'h1C
`define ESWC_OFF_FIR1_THR 8'h20
`define ESWC_OFF_FIR2 8'h24

// writable bits; reserved bits are held at zero
`define ESWC_MASK_GEOMETRY 32'hFF1FFFFF
`define ESWC_MASK_START 32'h0FFF0FFF
`define ESWC_MASK_BLACK 32'h0FFF007F
`define ESWC_MASK_SUBSAMPLE 32'h00000F0F
`define ESWC_MASK_OUT_CFG 32'h0000030F
`define ESWC_MASK_FIR1_THR 32'hFFFF00FF
`define ESWC_MASK_ALL 32'hFFFFFFFF
// readable bits of the line register; the start line delay is write only
`define ESWC_RMASK_LINE 32'h0000FFFF

// field positions
`define ESWC_F_WIN_H 31:24
`define ESWC_F_WIN_W 20:13
`define ESWC_F_WIN_VC 12:6
`define ESWC_F_WIN_HC 5:0
`define ESWC_F_START_V 27:16
`define ESWC_F_START_H 11:0
`define ESWC_F_BLK_V 27:16
`define ESWC_F_BLK_H 6:0
`define ESWC_F_SUB_V 11:8
`define ESWC_F_SUB_H 3:0
`define ESWC_F_BASE_HI 31:6
`define ESWC_BASE_LOW_W 6
`define ESWC_F_FORMAT 9:8
`define ESWC_F_SHIFT 3:0
`define ESWC_F_SLV 31:16
`define ESWC_F_LSTART 15:0
`define ESWC_F_THR 31:16
`define ESWC_F_TAP4 7:0

// reset value of every register
`define ESWC_RST_REG 32'h00000000

`endif

// ---- eswc_pkg.sv ----
// types shared by both ends of the statistics window link
package eswc_pkg;

   // widest pixel the datapath carries
   localparam int ESWC_PIX_MAX = 16;

   typedef enum logic [1:0] {
      ESWC_IDLE,
      ESWC_DELAY,
      ESWC_ACTIVE
   } eswc_phase_t;

   typedef enum logic [1:0] {
      ESWC_FMT_SQUARES,
      ESWC_FMT_MINMAX,
      ESWC_FMT_ACCUM,
      ESWC_FMT_RESERVED
   } eswc_format_t;

   typedef struct packed {
      logic [31:0] geometry;
      logic [31:0] start;
      logic [31:0] black;
      logic [31:0] subsample;
      logic [31:0] base;
      logic [31:0] out_cfg;
      logic [31:0] line;
      logic [31:0] fir1;
      logic [31:0] fir1_thr;
      logic [31:0] fir2;
      logic [31:0] base_work;
      logic [3:0] shift_work;
      logic [31:0] rdata;
      logic vd_d;
      logic lv_d;
      eswc_phase_t phase;
      logic [15:0] delay;
      logic [15:0] y;
      logic [15:0] raw_x;
      logic in_rows;
      logic [6:0] row;
      logic [8:0] lin;
      logic [4:0] vsub;
      logic in_blk;
      logic [7:0] blin;
      logic [4:0] bsub;
      logic in_cols;
      logic [5:0] col;
      logic [8:0] pin;
      logic [4:0] hsub;
      logic [31:0] acc;
      logic sum_valid;
      logic [31:0] sum;
      logic [6:0] win_row;
      logic [5:0] win_col;
      logic win_black;
   } eswc_dev_state_t;

   typedef struct packed {
      logic vd;
      logic lv;
      logic pv;
      logic [ESWC_PIX_MAX-1:0] pix;
   } eswc_src_state_t;

endpackage

// ---- eswc_link_if.sv ----
// pixel stream link between the sensor interface end and the statistics end
`timescale 1ns/1ns
interface eswc_link_if #(
   parameter int PIX_W = 12
);
   logic vertical_drive;
   logic line_valid;
   logic pixel_valid;
   logic [PIX_W-1:0] pixel;

   modport sensor (
      output vertical_drive,
      output line_valid,
      output pixel_valid,
      output pixel
   );

   modport stats (
      input vertical_drive,
      input line_valid,
      input pixel_valid,
      input pixel
   );
endinterface

// ---- eswc_sensor_src.sv ----
// sensor interface end: registers the user pixel stream onto the link
`timescale 1ns/1ns
`include "eswc_defs.svh"
module eswc_sensor_src import eswc_pkg::*; #(
   parameter int PIX_W = 12
) (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // link
   eswc_link_if.sensor LINK,
   // user pixel stream
   input wire logic VD_I,
   input wire logic LINE_VALID_I,
   input wire logic PIXEL_VALID_I,
   input wire logic [PIX_W-1:0] PIXEL_I
);

   if (PIX_W < 1 || PIX_W > ESWC_PIX_MAX) begin : g_bad_width
      $error("pixel width out of range");
   end

   eswc_src_state_t s;
   eswc_src_state_t next_s;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      next_s.vd = VD_I;
      next_s.lv = LINE_VALID_I;
      // pixels are only offered inside a line
      next_s.pv = PIXEL_VALID_I & LINE_VALID_I;
      next_s.pix = '0;
      next_s.pix[PIX_W-1:0] = PIXEL_I;
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign LINK.vertical_drive = s.vd;
   assign LINK.line_valid = s.lv;
   assign LINK.pixel_valid = s.pv;
   assign LINK.pixel = s.pix[PIX_W-1:0];

endmodule

// ---- eswc_stats_cfg.sv ----
// statistics end: window configuration bank and window geometry walker
// Notes on behaviour
// - window height is twice height code plus one
// - window width is twice width code plus one
// - vertical count field is window rows minus one
// - horizontal count field is window columns minus one
// - regular rows start at programmed vertical line
// - each window row starts at programmed column
// - one black row, own start, shared columns
// - black row height twice code plus one
// - vertical sample step twice code plus one
// - horizontal sample step twice code plus one
// - output base drops low six address bits
// - base write takes effect next frame
// - format field selects output packet content
// - window sums right-shifted before packing
// - shift shadowed, loaded at vertical drive rise
// - frame starts delay lines after drive rise
// - line storage starts at programmed pixel
// - first vertical filter: five taps, threshold
// - software writes zero to reserved bits
// - second vertical filter taps packed low-high
`timescale 1ns/1ns
`include "eswc_defs.svh"
module eswc_stats_cfg import eswc_pkg::*; #(
   parameter int PIX_W = 12
) (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // link
   eswc_link_if.stats LINK,
   // register port
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [31:0] REG_RDATA_O,
   // window results
   output logic SUM_VALID_O,
   output logic [31:0] SUM_O,
   output logic [6:0] WIN_ROW_O,
   output logic [5:0] WIN_COL_O,
   output logic WIN_BLACK_O,
   output logic FRAME_ACTIVE_O,
   // working configuration for the packer and focus filters
   output logic [31:0] OUT_BASE_O,
   output eswc_format_t OUT_FORMAT_O,
   output logic [39:0] FIR1_TAPS_O,
   output logic [15:0] FIR1_THRESHOLD_O,
   output logic [31:0] FIR2_TAPS_O
);

   if (PIX_W < 1 || PIX_W > ESWC_PIX_MAX) begin : g_bad_width
      $error("pixel width out of range");
   end

   eswc_dev_state_t s;
   eswc_dev_state_t next_s;

   logic vd_rise;
   logic line_go;
   logic line_end;
   logic pixel_go;
   logic line_samp;
   logic [15:0] x;
   logic [31:0] pix32;
   logic [31:0] sum;

   assign vd_rise = LINK.vertical_drive & ~s.vd_d;
   assign line_go = LINK.line_valid & ~s.lv_d;
   assign line_end = ~LINK.line_valid & s.lv_d;
   assign pixel_go = LINK.pixel_valid & LINK.line_valid;
   assign pix32 = {{(32 - PIX_W){1'b0}}, LINK.pixel};

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      x = '0;
      sum = '0;
      line_samp = 1'b0;
      next_s.vd_d = LINK.vertical_drive;
      next_s.lv_d = LINK.line_valid;
      next_s.sum_valid = 1'b0;

      // register writes; reserved bits are masked to zero
      if (REG_WR_I) begin
         unique case (REG_ADDR_I)
            `ESWC_OFF_GEOMETRY: next_s.geometry = REG_WDATA_I & `ESWC_MASK_GEOMETRY;
            `ESWC_OFF_START: next_s.start = REG_WDATA_I & `ESWC_MASK_START;
            `ESWC_OFF_BLACK: next_s.black = REG_WDATA_I & `ESWC_MASK_BLACK;
            `ESWC_OFF_SUBSAMPLE: next_s.subsample = REG_WDATA_I & `ESWC_MASK_SUBSAMPLE;
            `ESWC_OFF_BASE: next_s.base = REG_WDATA_I;
            `ESWC_OFF_OUT_CFG: next_s.out_cfg = REG_WDATA_I & `ESWC_MASK_OUT_CFG;
            `ESWC_OFF_LINE: next_s.line = REG_WDATA_I;
            `ESWC_OFF_FIR1: next_s.fir1 = REG_WDATA_I;
            `ESWC_OFF_FIR1_THR: next_s.fir1_thr = REG_WDATA_I & `ESWC_MASK_FIR1_THR;
            `ESWC_OFF_FIR2: next_s.fir2 = REG_WDATA_I;
            default: ;
         endcase
      end

      // read data stand only in the cycle after the strobe
      next_s.rdata = '0;
      if (REG_RD_I) begin
         unique case (REG_ADDR_I)
            `ESWC_OFF_GEOMETRY: next_s.rdata = s.geometry;
            `ESWC_OFF_START: next_s.rdata = s.start;
            `ESWC_OFF_BLACK: next_s.rdata = s.black;
            `ESWC_OFF_SUBSAMPLE: next_s.rdata = s.subsample;
            `ESWC_OFF_BASE: next_s.rdata = s.base;
            `ESWC_OFF_OUT_CFG: next_s.rdata = s.out_cfg;
            `ESWC_OFF_LINE: next_s.rdata = s.line & `ESWC_RMASK_LINE;
            `ESWC_OFF_FIR1: next_s.rdata = s.fir1;
            `ESWC_OFF_FIR1_THR: next_s.rdata = s.fir1_thr;
            `ESWC_OFF_FIR2: next_s.rdata = s.fir2;
            default: next_s.rdata = '0;
         endcase
      end

      // frame start: shadowed settings move to the working copies
      if (vd_rise) begin
         next_s.shift_work = s.out_cfg[`ESWC_F_SHIFT];
         next_s.base_work = s.base;
         next_s.delay = s.line[`ESWC_F_SLV];
         next_s.phase = (s.line[`ESWC_F_SLV] == 16'h0000) ? ESWC_ACTIVE : ESWC_DELAY;
         next_s.y = '0;
         next_s.in_rows = 1'b0;
         next_s.in_blk = 1'b0;
         next_s.in_cols = 1'b0;
      end else if (line_end) begin
         if (s.phase == ESWC_DELAY) begin
            next_s.delay = s.delay - 16'h0001;
            if (s.delay == 16'h0001) begin
               next_s.phase = ESWC_ACTIVE;
            end
         end else if (s.phase == ESWC_ACTIVE) begin
            next_s.y = s.y + 16'h0001;
            if (s.in_rows) begin
               if (s.lin == {s.geometry[`ESWC_F_WIN_H], 1'b1}) begin
                  next_s.lin = '0;
                  next_s.vsub = '0;
                  next_s.row = s.row + 7'h01;
                  if (s.row == s.geometry[`ESWC_F_WIN_VC]) begin
                     next_s.in_rows = 1'b0;
                  end
               end else begin
                  next_s.lin = s.lin + 9'h001;
                  next_s.vsub = (s.vsub == {s.subsample[`ESWC_F_SUB_V], 1'b1}) ?
                     5'h00 : s.vsub + 5'h01;
               end
            end
            if (s.in_blk) begin
               if (s.blin == {s.black[`ESWC_F_BLK_H], 1'b1}) begin
                  next_s.in_blk = 1'b0;
               end else begin
                  next_s.blin = s.blin + 8'h01;
                  next_s.bsub = (s.bsub == {s.subsample[`ESWC_F_SUB_V], 1'b1}) ?
                     5'h00 : s.bsub + 5'h01;
               end
            end
         end
      end

      // line start: row entry and column walker reset
      if (line_go && !vd_rise) begin
         next_s.raw_x = '0;
         next_s.in_cols = 1'b0;
         if (s.phase == ESWC_ACTIVE) begin
            if (s.y == {4'h0, s.start[`ESWC_F_START_V]}) begin
               next_s.in_rows = 1'b1;
               next_s.row = '0;
               next_s.lin = '0;
               next_s.vsub = '0;
            end
            if (s.y == {4'h0, s.black[`ESWC_F_BLK_V]}) begin
               next_s.in_blk = 1'b1;
               next_s.blin = '0;
               next_s.bsub = '0;
            end
         end
      end

      // pixel walk across the window columns
      if (pixel_go && next_s.phase == ESWC_ACTIVE) begin
         // the first pixel of a line sits at position zero
         if ((next_s.in_rows || next_s.in_blk) &&
             next_s.raw_x >= s.line[`ESWC_F_LSTART]) begin
            x = next_s.raw_x - s.line[`ESWC_F_LSTART];
            if (x == {4'h0, s.start[`ESWC_F_START_H]}) begin
               next_s.in_cols = 1'b1;
               next_s.col = '0;
               next_s.pin = '0;
               next_s.hsub = '0;
               next_s.acc = '0;
            end
            line_samp = next_s.in_rows ? (next_s.vsub == 5'h00) : (next_s.bsub == 5'h00);
            if (next_s.in_cols) begin
               sum = next_s.acc + ((line_samp && next_s.hsub == 5'h00) ? pix32 : 32'h0);
               if (next_s.pin == {s.geometry[`ESWC_F_WIN_W], 1'b1}) begin
                  // window closes; the next one abuts it
                  next_s.sum_valid = line_samp;
                  next_s.sum = sum >> s.shift_work;
                  next_s.win_row = next_s.in_rows ? next_s.row : 7'h00;
                  next_s.win_col = next_s.col;
                  next_s.win_black = ~next_s.in_rows;
                  if (next_s.col == s.geometry[`ESWC_F_WIN_HC]) begin
                     next_s.in_cols = 1'b0;
                  end
                  next_s.col = next_s.col + 6'h01;
                  next_s.pin = '0;
                  next_s.hsub = '0;
                  next_s.acc = '0;
               end else begin
                  next_s.pin = next_s.pin + 9'h001;
                  next_s.hsub = (next_s.hsub == {s.subsample[`ESWC_F_SUB_H], 1'b1}) ?
                     5'h00 : next_s.hsub + 5'h01;
                  next_s.acc = sum;
               end
            end
         end
         next_s.raw_x = next_s.raw_x + 16'h0001;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign REG_RDATA_O = s.rdata;
   assign SUM_VALID_O = s.sum_valid;
   assign SUM_O = s.sum;
   assign WIN_ROW_O = s.win_row;
   assign WIN_COL_O = s.win_col;
   assign WIN_BLACK_O = s.win_black;
   assign FRAME_ACTIVE_O = (s.phase == ESWC_ACTIVE);
   assign OUT_BASE_O = {s.base_work[`ESWC_F_BASE_HI], {`ESWC_BASE_LOW_W{1'b0}}};
   assign OUT_FORMAT_O = eswc_format_t'(s.out_cfg[`ESWC_F_FORMAT]);
   assign FIR1_TAPS_O = {s.fir1_thr[`ESWC_F_TAP4], s.fir1};
   assign FIR1_THRESHOLD_O = s.fir1_thr[`ESWC_F_THR];
   assign FIR2_TAPS_O = s.fir2;

endmodule

// ---- eswc_chk.sv ----
// concurrent checks on the pixel link and the statistics end outputs
`timescale 1ns/1ns
module eswc_chk (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // link and sensor end user side
   input wire logic vertical_drive,
   input wire logic line_valid,
   input wire logic pixel_valid,
   input wire logic VD_I,
   input wire logic LINE_VALID_I,
   input wire logic PIXEL_VALID_I,
   // statistics end
   input wire logic REG_RD_I,
   input wire logic [31:0] REG_RDATA_O,
   input wire logic [31:0] OUT_BASE_O,
   input wire logic SUM_VALID_O,
   input wire logic [6:0] WIN_ROW_O,
   input wire logic WIN_BLACK_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   ////////////////////////////////////////
   a_drive_copy: assert property (vertical_drive == $past(VD_I))
      else $error("drive not copied one cycle late");
   a_line_copy: assert property (line_valid == $past(LINE_VALID_I))
      else $error("line valid not copied one cycle late");
   a_pixel_gate: assert property (pixel_valid == $past(PIXEL_VALID_I && LINE_VALID_I))
      else $error("pixel valid not gated by line");
   a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
      else $error("read data outside its cycle");
   a_base_aligned: assert property (OUT_BASE_O[5:0] == 6'h0)
      else $error("output base not on 64 byte boundary");
   a_base_frame: assert property ($changed(OUT_BASE_O) |-> $past(vertical_drive) ||
      $past(vertical_drive, 2))
      else $error("output base changed mid frame");
   a_sum_after_pixel: assert property (SUM_VALID_O |-> $past(pixel_valid))
      else $error("result without a closing pixel");
   a_sum_pulse_gap: assert property (SUM_VALID_O |=> !SUM_VALID_O)
      else $error("windows narrower than two pixels");
   a_black_row_zero: assert property (SUM_VALID_O && WIN_BLACK_O |-> WIN_ROW_O == 7'h0)
      else $error("black row index not zero");
endmodule

// ---- exposure_stats_window_config_bench.sv ----
// self-checking bench joining the sensor end and the statistics end
`timescale 1ns/1ns
`include "eswc_defs.svh"
module exposure_stats_window_config_bench import eswc_pkg::*; ;
   logic CLK_SYS_I = 0;
   logic RST_I = 1;
   logic VD_I = 0;
   logic LINE_VALID_I = 0;
   logic PIXEL_VALID_I = 0;
   logic [11:0] PIXEL_I = '0;
   logic [7:0] REG_ADDR_I = '0;
   logic [31:0] REG_WDATA_I = '0;
   logic REG_WR_I = 0;
   logic REG_RD_I = 0;
   logic [31:0] REG_RDATA_O, SUM_O, OUT_BASE_O, FIR2_TAPS_O;
   logic SUM_VALID_O, WIN_BLACK_O, FRAME_ACTIVE_O;
   logic [6:0] WIN_ROW_O;
   logic [5:0] WIN_COL_O;
   eswc_format_t OUT_FORMAT_O;
   logic [39:0] FIR1_TAPS_O;
   logic [15:0] FIR1_THRESHOLD_O;
   int error_cnt = 0;
   int n_checks = 0;
   int sh = 0;
   logic [31:0] lfsr_st = 32'hDFCD250B;
   logic [45:0] exp_q[$];
   logic [7:0] offs[10] = '{`ESWC_OFF_GEOMETRY, `ESWC_OFF_START, `ESWC_OFF_BLACK,
      `ESWC_OFF_SUBSAMPLE, `ESWC_OFF_BASE, `ESWC_OFF_OUT_CFG, `ESWC_OFF_LINE,
      `ESWC_OFF_FIR1, `ESWC_OFF_FIR1_THR, `ESWC_OFF_FIR2};
   logic [31:0] wm[10] = '{`ESWC_MASK_GEOMETRY, `ESWC_MASK_START, `ESWC_MASK_BLACK,
      `ESWC_MASK_SUBSAMPLE, `ESWC_MASK_ALL, `ESWC_MASK_OUT_CFG, `ESWC_RMASK_LINE,
      `ESWC_MASK_ALL, `ESWC_MASK_FIR1_THR, `ESWC_MASK_ALL};

   eswc_link_if #(.PIX_W(12)) eswc_link_if_inst ();
   eswc_sensor_src #(.PIX_W(12)) eswc_sensor_src_inst (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
      .LINK(eswc_link_if_inst), .VD_I(VD_I), .LINE_VALID_I(LINE_VALID_I),
      .PIXEL_VALID_I(PIXEL_VALID_I), .PIXEL_I(PIXEL_I));
   eswc_stats_cfg #(.PIX_W(12)) eswc_stats_cfg_inst (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
      .LINK(eswc_link_if_inst), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
      .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
      .SUM_VALID_O(SUM_VALID_O), .SUM_O(SUM_O), .WIN_ROW_O(WIN_ROW_O), .WIN_COL_O(WIN_COL_O),
      .WIN_BLACK_O(WIN_BLACK_O), .FRAME_ACTIVE_O(FRAME_ACTIVE_O), .OUT_BASE_O(OUT_BASE_O),
      .OUT_FORMAT_O(OUT_FORMAT_O), .FIR1_TAPS_O(FIR1_TAPS_O),
      .FIR1_THRESHOLD_O(FIR1_THRESHOLD_O), .FIR2_TAPS_O(FIR2_TAPS_O));
   eswc_chk eswc_chk_inst (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
      .vertical_drive(eswc_link_if_inst.vertical_drive),
      .line_valid(eswc_link_if_inst.line_valid), .pixel_valid(eswc_link_if_inst.pixel_valid),
      .VD_I(VD_I), .LINE_VALID_I(LINE_VALID_I), .PIXEL_VALID_I(PIXEL_VALID_I),
      .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .OUT_BASE_O(OUT_BASE_O),
      .SUM_VALID_O(SUM_VALID_O), .WIN_ROW_O(WIN_ROW_O), .WIN_BLACK_O(WIN_BLACK_O));

   ////////////////////////////////////////
   initial begin
      forever #5 CLK_SYS_I = ~CLK_SYS_I;
   end

   function automatic logic [31:0] lfsr();
      lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
      return lfsr_st;
   endfunction

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_res(input logic [45:0] got, input logic [45:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   ////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS_I);
      REG_WR_I <= 1;
      REG_ADDR_I <= a;
      REG_WDATA_I <= d;
      @(posedge CLK_SYS_I);
      REG_WR_I <= 0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK_SYS_I);
      REG_RD_I <= 1;
      REG_ADDR_I <= a;
      @(posedge CLK_SYS_I);
      REG_RD_I <= 0;
      @(negedge CLK_SYS_I);
      d = REG_RDATA_O;
   endtask

   task automatic vd_pulse();
      @(posedge CLK_SYS_I);
      VD_I <= 1;
      repeat (2) @(posedge CLK_SYS_I);
      VD_I <= 0;
      repeat (3) @(posedge CLK_SYS_I);
      @(negedge CLK_SYS_I);
   endtask

   // model: rows at lines 1..4 height 2, black row at line 6, two windows of four pixels
   task automatic send_line(input int y, input bit model);
      logic [11:0] p[12];
      logic [31:0] s;
      int row;
      bit blk;
      bit smp;
      for (int i = 0; i < 12; i++) p[i] = 12'(lfsr());
      smp = 0;
      blk = 0;
      row = 0;
      if (y >= 1 && y < 5 && (y - 1) % 2 == 0) begin
         smp = 1;
         row = (y - 1) / 2;
      end else if (y == 6) begin
         smp = 1;
         blk = 1;
      end
      for (int c = 0; c < 2 && model && smp; c++) begin
         s = 32'(p[3 + 4 * c]) + 32'(p[5 + 4 * c]);
         exp_q.push_back({blk, 7'(row), 6'(c), s >> sh});
      end
      for (int i = 0; i < 12; i++) begin
         @(posedge CLK_SYS_I);
         LINE_VALID_I <= 1;
         PIXEL_VALID_I <= 1;
         PIXEL_I <= p[i];
      end
      @(posedge CLK_SYS_I);
      LINE_VALID_I <= 0;
      PIXEL_VALID_I <= 0;
      repeat (3) @(posedge CLK_SYS_I);
   endtask

   // results are looked at mid-cycle, while they stand
   always @(negedge CLK_SYS_I) begin
      if (SUM_VALID_O === 1'b1) begin
         chk_res({WIN_BLACK_O, WIN_ROW_O, WIN_COL_O, SUM_O},
            exp_q.size() ? exp_q.pop_front() : '1);
      end
   end

   ////////////////////////////////////////
   initial begin
      logic [31:0] rv[10];
      logic [31:0] d, b1, b2;
      int s1, s2;
      repeat (20) @(posedge CLK_SYS_I);
      RST_I <= 0;
      for (int i = 0; i < 10; i++) begin
         rd(offs[i], d);
         chk(d, `ESWC_RST_REG);
         rv[i] = lfsr();
         wr(offs[i], rv[i]);
         rd(offs[i], d);
         chk(d, rv[i] & wm[i]);
      end
      chk(FIR1_TAPS_O, {rv[8][7:0], rv[7]});
      chk(FIR1_THRESHOLD_O, rv[8][31:16]);
      chk(FIR2_TAPS_O, rv[9]);
      wr(8'h28, lfsr());
      rd(8'h28, d);
      chk(d, 32'h0);
      for (int f = 0; f < 4; f++) begin
         wr(`ESWC_OFF_OUT_CFG, 32'(f) << 8);
         @(negedge CLK_SYS_I);
         chk(OUT_FORMAT_O, f);
      end
      wr(`ESWC_OFF_GEOMETRY, 32'h00002041);
      wr(`ESWC_OFF_START, 32'h00010002);
      wr(`ESWC_OFF_BLACK, 32'h00060000);
      wr(`ESWC_OFF_SUBSAMPLE, 32'h0);
      wr(`ESWC_OFF_LINE, 32'h00010001);
      s1 = int'(lfsr() % 16);
      s2 = (s1 + 5) % 16;
      b1 = lfsr();
      b2 = lfsr();
      wr(`ESWC_OFF_OUT_CFG, 32'h200 | 32'(s1));
      wr(`ESWC_OFF_BASE, b1);
      for (int f = 0; f < 2; f++) begin
         if (f == 1) wr(`ESWC_OFF_LINE, 32'h00000001);
         sh = f ? s2 : s1;
         vd_pulse();
         chk(FRAME_ACTIVE_O, f);
         chk(OUT_BASE_O, (f ? b2 : b1) & 32'hFFFFFFC0);
         if (f == 0) begin
            wr(`ESWC_OFF_OUT_CFG, 32'h200 | 32'(s2));
            wr(`ESWC_OFF_BASE, b2);
            rd(`ESWC_OFF_BASE, d);
            chk(d, b2);
            chk(OUT_BASE_O, b1 & 32'hFFFFFFC0);
            send_line(0, 0);
            @(negedge CLK_SYS_I);
            chk(FRAME_ACTIVE_O, 1);
         end
         for (int y = 0; y < 9; y++) send_line(y, 1);
         repeat (5) @(posedge CLK_SYS_I);
         @(negedge CLK_SYS_I);
         chk(exp_q.size(), 0);
      end
      give_verdict();
   end

   initial begin
      repeat (50000) @(posedge CLK_SYS_I);
      error_cnt++;
      give_verdict();
   end
endmodule
